// ==== src/oas_addr_gen.sv ====
// Combinational effective-address generator for data operands
`timescale 1ns/1ps
module oas_addr_gen
	import oas_pkg::*;
(
	oas_addr_if.generator ag
);
	wire [15:0] idx_b = {8'h00, ag.pair1[15:8]};
	wire [15:0] idx_c = {8'h00, ag.pair1[7:0]};
	wire [15:0] off8 = {8'h00, ag.imm8};
	logic [15:0] low16;
	logic is_special;
	logic is_stack;
	always_comb begin
		low16 = 16'h0000;
		is_special = 1'b0;
		is_stack = 1'b0;
		case (ag.mode)
			OAS_AM_SPECIAL: begin
				low16 = {8'hff, ag.imm8};
				is_special = 1'b1;
			end
			OAS_AM_IND_PAIR2: low16 = ag.pair2;
			OAS_AM_IND_PAIR3: low16 = ag.pair3;
			OAS_AM_PAIR2_BYTE: low16 = ag.pair2 + off8;
			OAS_AM_PAIR3_BYTE: low16 = ag.pair3 + off8;
			OAS_AM_STACK_BYTE: begin
				low16 = ag.stack_ptr + off8;
				is_stack = 1'b1;
			end
			OAS_AM_WORD_IDXB: low16 = ag.imm16 + idx_b;
			OAS_AM_WORD_IDXC: low16 = ag.imm16 + idx_c;
			OAS_AM_WORD_PAIR1: low16 = ag.imm16 + ag.pair1;
			OAS_AM_PAIR3_IDXB: low16 = ag.pair3 + idx_b;
			OAS_AM_PAIR3_IDXC: low16 = ag.pair3 + idx_c;
			default: low16 = 16'h0000;
		endcase
	end
	wire use_bank = ag.bank_prefix && !is_special && !is_stack;
	assign ag.addr = {use_bank ? ag.upper_bank_selector : NEAR_BANK, low16};
	assign ag.addr_err = (is_special && ag.wide && ag.imm8[0]) || (ag.bank_prefix && (is_special || is_stack));
endmodule

// ==== src/oas_addr_if.sv ====
// Interface carrying one effective-address request and its result
`timescale 1ns/1ps
interface oas_addr_if;
	import oas_pkg::*;
	logic [3:0] mode;
	logic bank_prefix;
	logic wide;
	logic [7:0] imm8;
	logic [15:0] imm16;
	logic [15:0] pair1;
	logic [15:0] pair2;
	logic [15:0] pair3;
	logic [15:0] stack_ptr;
	logic [3:0] upper_bank_selector;
	logic [19:0] addr;
	logic addr_err;
	modport requester (output mode, bank_prefix, wide, imm8, imm16, pair1, pair2, pair3, stack_ptr,
		upper_bank_selector, input addr, addr_err);
	modport generator (input mode, bank_prefix, wide, imm8, imm16, pair1, pair2, pair3, stack_ptr,
		upper_bank_selector, output addr, addr_err);
endinterface

// ==== src/oas_pkg.sv ====
// Package of constants and types for the operand address and stack unit
package oas_pkg;
	localparam int ADDR_W = 20;
	localparam logic [11:0] SPECIAL_BASE_HI = 12'hfff;
	localparam logic [3:0] NEAR_BANK = 4'hf;
	localparam logic [15:0] STACK_RESET = 16'h0000;
	localparam logic [3:0] STACK_BANK = 4'hf;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	typedef enum logic [3:0] {
		OAS_AM_SPECIAL,
		OAS_AM_IND_PAIR2,
		OAS_AM_IND_PAIR3,
		OAS_AM_PAIR2_BYTE,
		OAS_AM_PAIR3_BYTE,
		OAS_AM_STACK_BYTE,
		OAS_AM_WORD_IDXB,
		OAS_AM_WORD_IDXC,
		OAS_AM_WORD_PAIR1,
		OAS_AM_PAIR3_IDXB,
		OAS_AM_PAIR3_IDXC
	} oas_mode_e;

	typedef enum logic [2:0] {
		OAS_OP_NONE,
		OAS_OP_PUSH,
		OAS_OP_POP,
		OAS_OP_CALL,
		OAS_OP_RET,
		OAS_OP_INTSAVE,
		OAS_OP_INTRET
	} oas_op_e;
endpackage

// ==== src/oas_unit.sv ====
// Operand address and stack sequencing unit top level
`timescale 1ns/1ps
module oas_unit
	import oas_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic addr_req,
	input wire logic [3:0] addr_mode,
	input wire logic addr_bank_prefix,
	input wire logic addr_wide,
	input wire logic [7:0] imm8,
	input wire logic [15:0] imm16,
	input wire logic [15:0] pointer_pair_one,
	input wire logic [15:0] pointer_pair_two,
	input wire logic [15:0] pointer_pair_three,
	input wire logic [3:0] upper_bank_selector,
	input wire logic stk_req,
	input wire logic [2:0] stk_op,
	input wire logic stk_flags_sel,
	input wire logic [15:0] stk_push_data,
	input wire logic [7:0] processor_flags_word,
	input wire logic [19:0] next_instruction_ptr,
	input wire logic sp_load,
	input wire logic [15:0] sp_load_value,
	input wire logic [7:0] mem_rdata,
	output logic [19:0] data_addr,
	output logic data_addr_valid,
	output logic data_addr_err,
	output logic [19:0] mem_addr,
	output logic mem_we,
	output logic mem_re,
	output logic [7:0] mem_wdata,
	output logic [15:0] stack_ptr,
	output logic stk_busy,
	output logic stk_done,
	output logic [15:0] pop_data,
	output logic [19:0] restored_instruction_ptr,
	output logic [7:0] restored_flags
);
	////////////////////////////////////////////////////////////////
	// Address generation
	logic [15:0] stack_ptr_reg;
	oas_addr_if ag ();
	assign ag.mode = addr_mode;
	assign ag.bank_prefix = addr_bank_prefix;
	assign ag.wide = addr_wide;
	assign ag.imm8 = imm8;
	assign ag.imm16 = imm16;
	assign ag.pair1 = pointer_pair_one;
	assign ag.pair2 = pointer_pair_two;
	assign ag.pair3 = pointer_pair_three;
	assign ag.stack_ptr = stack_ptr_reg;
	assign ag.upper_bank_selector = upper_bank_selector;
	oas_addr_gen u_gen (
		.ag(ag)
	);

	logic [19:0] data_addr_reg;
	logic data_addr_valid_reg;
	logic data_addr_err_reg;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_addr_reg <= 20'h0_0000;
			data_addr_valid_reg <= 1'b0;
			data_addr_err_reg <= 1'b0;
		end else begin
			data_addr_reg <= ag.addr;
			data_addr_valid_reg <= addr_req;
			data_addr_err_reg <= addr_req && ag.addr_err;
		end
	end
	assign data_addr = data_addr_reg;
	assign data_addr_valid = data_addr_valid_reg;
	assign data_addr_err = data_addr_err_reg;

	////////////////////////////////////////////////////////////////
	// Stack sequencer
	typedef enum logic [1:0] {OAS_ST_IDLE, OAS_ST_RUN, OAS_ST_DONE} oas_state_e;
	oas_state_e state_reg, state_next;
	oas_op_e op_reg;
	logic flags_reg;
	logic [1:0] step_reg;
	logic [15:0] push_data_reg;
	logic [7:0] save_flags_reg;
	logic [19:0] save_ip_reg;
	logic [15:0] pop_data_reg;
	logic [19:0] rest_ip_reg;
	logic [7:0] rest_flags_reg;
	logic [1:0] rd_step_reg;
	logic [19:0] mem_addr_reg;
	logic mem_we_reg;
	logic mem_re_reg;
	logic [7:0] mem_wdata_reg;

	wire op_ok = stk_req && (state_reg == OAS_ST_IDLE) && (stk_op != OAS_OP_NONE);
	wire is_push = (op_reg == OAS_OP_PUSH);
	wire is_pop = (op_reg == OAS_OP_POP);
	wire is_write = (op_reg == OAS_OP_PUSH) || (op_reg == OAS_OP_CALL) || (op_reg == OAS_OP_INTSAVE);
	wire [1:0] last_step = (is_push || is_pop) ? 2'd1 : 2'd3;
	wire last = (step_reg == last_step);

	wire [15:0] wr_off = stack_ptr_reg - 16'(step_reg) - 16'd1;
	wire [15:0] rd_off = stack_ptr_reg + 16'(step_reg);

	logic [7:0] wr_byte;
	always_comb begin
		wr_byte = ZERO_BYTE;
		case (op_reg)
			OAS_OP_PUSH: begin
				if (flags_reg) begin
					wr_byte = (step_reg == 2'd0) ? save_flags_reg : ZERO_BYTE;
				end else begin
					wr_byte = (step_reg == 2'd0) ? push_data_reg[15:8] : push_data_reg[7:0];
				end
			end
			OAS_OP_CALL: begin
				case (step_reg)
					2'd0: wr_byte = ZERO_BYTE;
					2'd1: wr_byte = {4'h0, save_ip_reg[19:16]};
					2'd2: wr_byte = save_ip_reg[15:8];
					default: wr_byte = save_ip_reg[7:0];
				endcase
			end
			OAS_OP_INTSAVE: begin
				case (step_reg)
					2'd0: wr_byte = save_flags_reg;
					2'd1: wr_byte = {4'h0, save_ip_reg[19:16]};
					2'd2: wr_byte = save_ip_reg[15:8];
					default: wr_byte = save_ip_reg[7:0];
				endcase
			end
			default: wr_byte = ZERO_BYTE;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			OAS_ST_IDLE: begin
				if (op_ok) begin
					state_next = OAS_ST_RUN;
				end
			end
			OAS_ST_RUN: begin
				if (last) begin
					state_next = OAS_ST_DONE;
				end
			end
			default: state_next = OAS_ST_IDLE;
		endcase
	end

	wire [15:0] sp_delta = (is_push || is_pop) ? 16'd2 : 16'd4;
	wire [15:0] sp_final = is_write ? (stack_ptr_reg - sp_delta) : (stack_ptr_reg + sp_delta);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= OAS_ST_IDLE;
			op_reg <= OAS_OP_NONE;
			flags_reg <= 1'b0;
			step_reg <= 2'd0;
			push_data_reg <= 16'h0000;
			save_flags_reg <= ZERO_BYTE;
			save_ip_reg <= 20'h0_0000;
		end else begin
			state_reg <= state_next;
			if (op_ok) begin
				op_reg <= oas_op_e'(stk_op);
				flags_reg <= stk_flags_sel;
				step_reg <= 2'd0;
				push_data_reg <= stk_push_data;
				save_flags_reg <= processor_flags_word;
				save_ip_reg <= next_instruction_ptr;
			end else if (state_reg == OAS_ST_RUN) begin
				step_reg <= step_reg + 2'd1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stack_ptr_reg <= STACK_RESET;
		end else if (state_reg == OAS_ST_RUN && last) begin
			stack_ptr_reg <= sp_final;
		end else if (sp_load && state_reg == OAS_ST_IDLE) begin
			stack_ptr_reg <= sp_load_value;
		end
	end

	wire run = (state_reg == OAS_ST_RUN);
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_addr_reg <= 20'h0_0000;
			mem_we_reg <= 1'b0;
			mem_re_reg <= 1'b0;
			mem_wdata_reg <= ZERO_BYTE;
			rd_step_reg <= 2'd0;
		end else begin
			mem_addr_reg <= {STACK_BANK, is_write ? wr_off : rd_off};
			mem_we_reg <= run && is_write;
			mem_re_reg <= run && !is_write;
			mem_wdata_reg <= wr_byte;
			rd_step_reg <= step_reg;
		end
	end

	// Read data is captured in the same cycle as the strobe
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pop_data_reg <= 16'h0000;
			rest_ip_reg <= 20'h0_0000;
			rest_flags_reg <= ZERO_BYTE;
		end else if (mem_re_reg) begin
			if (op_reg == OAS_OP_POP) begin
				if (rd_step_reg == 2'd0) begin
					pop_data_reg[7:0] <= mem_rdata;
				end else begin
					pop_data_reg[15:8] <= mem_rdata;
					if (flags_reg) begin
						rest_flags_reg <= mem_rdata;
					end
				end
			end else begin
				case (rd_step_reg)
					2'd0: rest_ip_reg[7:0] <= mem_rdata;
					2'd1: rest_ip_reg[15:8] <= mem_rdata;
					2'd2: rest_ip_reg[19:16] <= mem_rdata[3:0];
					default: begin
						if (op_reg == OAS_OP_INTRET) begin
							rest_flags_reg <= mem_rdata;
						end
					end
				endcase
			end
		end
	end

	logic done_reg;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= (state_reg == OAS_ST_DONE);
		end
	end

	logic busy_reg;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= (state_next != OAS_ST_IDLE);
		end
	end

	assign mem_addr = mem_addr_reg;
	assign mem_we = mem_we_reg;
	assign mem_re = mem_re_reg;
	assign mem_wdata = mem_wdata_reg;
	assign stack_ptr = stack_ptr_reg;
	assign stk_busy = busy_reg;
	assign stk_done = done_reg;
	assign pop_data = pop_data_reg;
	assign restored_instruction_ptr = rest_ip_reg;
	assign restored_flags = rest_flags_reg;
endmodule

// ==== verification/oas_mem_model.sv ====
// Byte memory model behind the stack port
`timescale 1ns/1ps
module oas_mem_model (
	input wire logic core_clk,
	input wire logic [19:0] mem_addr,
	input wire logic mem_we,
	input wire logic mem_re,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] ram [0:65535];
	always @(posedge core_clk) begin
		if (mem_we) ram[mem_addr[15:0]] <= mem_wdata;
	end
	// Read data stands while the strobe is high
	assign mem_rdata = mem_re ? ram[mem_addr[15:0]] : ~ram[mem_addr[15:0]];
endmodule

// ==== verification/oas_unit_monitor.sv ====
// Port checker for the address and stack unit
`timescale 1ns/1ps
module oas_unit_monitor
	import oas_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic addr_req,
	input wire logic [3:0] addr_mode,
	input wire logic addr_bank_prefix,
	input wire logic addr_wide,
	input wire logic [7:0] imm8,
	input wire logic [3:0] upper_bank_selector,
	input wire logic stk_req,
	input wire logic [2:0] stk_op,
	input wire logic stk_flags_sel,
	input wire logic [15:0] stk_push_data,
	input wire logic [7:0] processor_flags_word,
	input wire logic [19:0] next_instruction_ptr,
	input wire logic [19:0] data_addr,
	input wire logic data_addr_err,
	input wire logic [19:0] mem_addr,
	input wire logic mem_we,
	input wire logic [7:0] mem_wdata,
	input wire logic [15:0] stack_ptr,
	input wire logic stk_busy,
	input wire logic stk_done
);
	logic [15:0] sp_take_reg;
	logic [2:0] op_take_reg;
	wire logic take = stk_req && !stk_busy;
	wire logic [15:0] sp_exp = (op_take_reg == OAS_OP_PUSH) ? sp_take_reg - 16'h0002 :
		(op_take_reg == OAS_OP_POP) ? sp_take_reg + 16'h0002 :
		(op_take_reg == OAS_OP_CALL || op_take_reg == OAS_OP_INTSAVE) ? sp_take_reg - 16'h0004 :
		sp_take_reg + 16'h0004;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sp_take_reg <= 16'h0000;
			op_take_reg <= 3'h0;
		end else if (take) begin
			sp_take_reg <= stack_ptr;
			op_take_reg <= stk_op;
		end
	end
	////////////////////////////////////////
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_take(logic [2:0] op);
		take && stk_op == op;
	endsequence
	sequence s_wr(logic [15:0] a, logic [7:0] d);
		mem_we && mem_addr == {STACK_BANK, a} && mem_wdata == d;
	endsequence
	a_special_map: assert property (addr_req && addr_mode == OAS_AM_SPECIAL |=>
		data_addr == {SPECIAL_BASE_HI, $past(imm8)}) else $error("special address wrong");
	a_wide_odd: assert property (addr_req && addr_mode == OAS_AM_SPECIAL && addr_wide && imm8[0]
		|=> data_addr_err) else $error("odd wide special not flagged");
	a_near_bank: assert property (addr_req && !addr_bank_prefix && addr_mode != OAS_AM_SPECIAL
		|=> data_addr[19:16] == NEAR_BANK) else $error("near bank wrong");
	a_bank_sel: assert property (addr_req && addr_bank_prefix && addr_mode != OAS_AM_SPECIAL
		&& addr_mode != OAS_AM_STACK_BYTE |=> data_addr[19:16] == $past(upper_bank_selector))
		else $error("bank selector not used");
	a_push_bytes: assert property (s_take(OAS_OP_PUSH) ##0 !stk_flags_sel |-> ##[1:4]
		s_wr(sp_take_reg - 16'h0001, stk_push_data[15:8]) ##1 s_wr(sp_take_reg - 16'h0002, stk_push_data[7:0]))
		else $error("push bytes wrong");
	a_flags_push: assert property (s_take(OAS_OP_PUSH) ##0 stk_flags_sel |-> ##[1:4]
		s_wr(sp_take_reg - 16'h0001, processor_flags_word) ##1 s_wr(sp_take_reg - 16'h0002, ZERO_BYTE))
		else $error("flags push wrong");
	a_intsave_order: assert property (s_take(OAS_OP_INTSAVE) |-> ##[1:4]
		s_wr(sp_take_reg - 16'h0001, processor_flags_word)
		##1 s_wr(sp_take_reg - 16'h0002, {4'h0, next_instruction_ptr[19:16]})
		##1 s_wr(sp_take_reg - 16'h0003, next_instruction_ptr[15:8])
		##1 s_wr(sp_take_reg - 16'h0004, next_instruction_ptr[7:0])) else $error("context save wrong");
	a_sp_adjust: assert property (stk_done |-> stack_ptr == sp_exp)
		else $error("stack pointer adjust wrong");
	a_done_bound: assert property (take && stk_op != OAS_OP_NONE |-> ##[3:14] stk_done)
		else $error("stack op not done");
endmodule
bind oas_unit oas_unit_monitor i_mon (.*);

// ==== verification/operand_address_and_stack_unit_test.sv ====
// Self-checking bench for the address and stack unit
`timescale 1ns/1ps
module operand_address_and_stack_unit_test;
	import oas_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic addr_req, addr_bank_prefix, addr_wide, stk_req, stk_flags_sel, sp_load, e_err;
	logic [3:0] addr_mode, upper_bank_selector;
	logic [7:0] imm8, processor_flags_word, mem_rdata, mem_wdata, restored_flags;
	logic [15:0] imm16, pointer_pair_one, pointer_pair_two, pointer_pair_three, stk_push_data;
	logic [15:0] sp_load_value, stack_ptr, pop_data, sp;
	logic [2:0] stk_op;
	logic [19:0] next_instruction_ptr, data_addr, mem_addr, restored_instruction_ptr, e_addr;
	logic data_addr_valid, data_addr_err, mem_we, mem_re, stk_busy, stk_done;
	logic [31:0] seed = 32'h0000_0003;
	int n_mismatch = 0;
	int checked = 0;
	oas_unit i_dut (.*);
	oas_mem_model i_mem (.*);
	always #5 core_clk = ~core_clk;
	////////////////////////////////////////
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [19:0] f_addr();
		logic [15:0] lo;
		case (addr_mode)
			OAS_AM_SPECIAL: return {SPECIAL_BASE_HI, imm8};
			OAS_AM_IND_PAIR2: lo = pointer_pair_two;
			OAS_AM_IND_PAIR3: lo = pointer_pair_three;
			OAS_AM_PAIR2_BYTE: lo = pointer_pair_two + 16'(imm8);
			OAS_AM_PAIR3_BYTE: lo = pointer_pair_three + 16'(imm8);
			OAS_AM_STACK_BYTE: lo = sp + 16'(imm8);
			OAS_AM_WORD_IDXB: lo = imm16 + 16'(pointer_pair_one[15:8]);
			OAS_AM_WORD_IDXC: lo = imm16 + 16'(pointer_pair_one[7:0]);
			OAS_AM_WORD_PAIR1: lo = imm16 + pointer_pair_one;
			OAS_AM_PAIR3_IDXB: lo = pointer_pair_three + 16'(pointer_pair_one[15:8]);
			default: lo = pointer_pair_three + 16'(pointer_pair_one[7:0]);
		endcase
		return {addr_bank_prefix ? upper_bank_selector : NEAR_BANK, lo};
	endfunction
	function logic [31:0] top4();
		return {i_mem.ram[sp + 16'h0003], i_mem.ram[sp + 16'h0002], i_mem.ram[sp + 16'h0001], i_mem.ram[sp]};
	endfunction
	task summarize();
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task stk(input logic [2:0] op, input logic fs, input logic [15:0] d);
		int i;
		stk_op = op;
		stk_flags_sel = fs;
		stk_req = 1'b1;
		@(negedge core_clk);
		stk_req = 1'b0;
		for (i = 0; i < 30 && stk_done !== 1'b1; i++) @(negedge core_clk);
		if (i == 30) begin
			n_mismatch++;
			summarize();
		end
		sp = sp + d;
		chk(32'(stack_ptr), 32'(sp));
		@(negedge core_clk);
	endtask
	////////////////////////////////////////
	initial begin
		{addr_req, addr_bank_prefix, addr_wide, stk_req, stk_flags_sel, sp_load} = 6'h00;
		{addr_mode, upper_bank_selector, stk_op, imm8, processor_flags_word} = 27'h000_0000;
		{imm16, pointer_pair_one, pointer_pair_two, pointer_pair_three} = 64'h0;
		{stk_push_data, sp_load_value, next_instruction_ptr} = 52'h0;
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		sys_rst = 1'b0;
		chk(32'(stack_ptr), 32'(STACK_RESET));
		sp = 16'hfe80;
		sp_load_value = sp;
		sp_load = 1'b1;
		@(negedge core_clk);
		sp_load = 1'b0;
		addr_req = 1'b1;
		repeat (400) begin
			{addr_bank_prefix, addr_wide, upper_bank_selector, imm8} = 14'(rnd());
			addr_mode = 4'(rnd() % 11);
			{imm16, pointer_pair_one} = rnd();
			{pointer_pair_two, pointer_pair_three} = rnd();
			e_addr = f_addr();
			e_err = (addr_bank_prefix && (addr_mode == OAS_AM_SPECIAL || addr_mode == OAS_AM_STACK_BYTE))
				|| (addr_mode == OAS_AM_SPECIAL && addr_wide && imm8[0]);
			@(negedge core_clk);
			chk(32'(data_addr_err), 32'(e_err));
			chk(32'(data_addr_valid), 32'h0000_0001);
			if (!addr_bank_prefix || addr_mode != OAS_AM_SPECIAL && addr_mode != OAS_AM_STACK_BYTE)
				chk(32'(data_addr), 32'(e_addr));
		end
		addr_req = 1'b0;
		$display("address test done");
		repeat (3) begin
			{stk_push_data, processor_flags_word} = 24'(rnd());
			next_instruction_ptr = 20'(rnd());
			stk(OAS_OP_PUSH, 1'b0, 16'hfffe);
			chk(32'({i_mem.ram[sp + 16'h0001], i_mem.ram[sp]}), 32'(stk_push_data));
			stk(OAS_OP_PUSH, 1'b1, 16'hfffe);
			chk(32'({i_mem.ram[sp + 16'h0001], i_mem.ram[sp]}), {16'h0, processor_flags_word, 8'h00});
			stk(OAS_OP_POP, 1'b1, 16'h0002);
			chk(32'(restored_flags), 32'(processor_flags_word));
			stk(OAS_OP_POP, 1'b0, 16'h0002);
			chk(32'(pop_data), 32'(stk_push_data));
			stk(OAS_OP_CALL, 1'b0, 16'hfffc);
			chk(top4(), {8'h00, 4'h0, next_instruction_ptr});
			stk(OAS_OP_RET, 1'b0, 16'h0004);
			chk(32'(restored_instruction_ptr), 32'(next_instruction_ptr));
			{processor_flags_word, next_instruction_ptr} = 28'(rnd());
			stk(OAS_OP_INTSAVE, 1'b0, 16'hfffc);
			chk(top4(), {processor_flags_word, 4'h0, next_instruction_ptr});
			stk(OAS_OP_INTRET, 1'b0, 16'h0004);
			chk(32'(restored_instruction_ptr), 32'(next_instruction_ptr));
			chk(32'(restored_flags), 32'(processor_flags_word));
		end
		$display("stack test done");
		summarize();
	end
endmodule
